// ### logic/pspi_pkg.sv
// Purpose: shared constants and types for the pipelined sram pin interface
// Assumes: one clock, synchronous active-low reset
// Notes:   widths follow the 512k x 72 organisation, eight 9-bit lanes
package pspi_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int ADDR_W  = 19;
   localparam int LANES   = 8;
   localparam int LANE_W  = 8;
   localparam int DATA_W  = LANES * LANE_W;
   localparam int BURST_W = 2;
   localparam int SYNC_N  = 3;

   // ***************************************************************
   // strap and reset values
   // ***************************************************************
   localparam logic MODE_LINEAR     = 1'b0;
   localparam logic MODE_INTERLEAVE = 1'b1;
   localparam logic MODE_FLOAT      = MODE_INTERLEAVE;
   localparam logic [LANES-1:0] BW_NONE = 8'hff;
   localparam logic [1:0] STRAP_FILL = 2'h3;

   // ***************************************************************
   // pipeline operation held in a stage
   // ***************************************************************
   typedef enum logic [2:0] {
      OP_DESEL = 3'b001,
      OP_READ  = 3'b010,
      OP_WRITE = 3'b100
   } pspi_op_t;

endpackage

// ### logic/pspi_core.sv
// Purpose: storage array with byte-lane writes and registered read port
// Assumes: caller qualifies both enables with the clock qualify term
// Notes:   a read meeting a write to the same word sees the new lanes
`timescale 1ns/100ps
`default_nettype none
module pspi_core (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         resetn,
   // read port
   input  wire logic                         rd_en,
   input  wire logic [pspi_pkg::ADDR_W-1:0]  rd_addr,
   output logic      [pspi_pkg::DATA_W-1:0]  q_data,
   output logic      [pspi_pkg::LANES-1:0]   q_par,
   // write port
   input  wire logic                         wr_en,
   input  wire logic [pspi_pkg::ADDR_W-1:0]  wr_addr,
   input  wire logic [pspi_pkg::LANES-1:0]   wr_lane_n,
   input  wire logic [pspi_pkg::DATA_W-1:0]  wr_data,
   input  wire logic [pspi_pkg::LANES-1:0]   wr_par
);

   typedef logic [pspi_pkg::LANES-1:0][pspi_pkg::LANE_W:0] pspi_word_t;

   typedef struct packed {
      pspi_word_t q;
   } pspi_core_st_t;

   pspi_word_t    mem [0:(2**pspi_pkg::ADDR_W)-1];
   pspi_core_st_t st_r;
   pspi_core_st_t st_nxt;
   pspi_word_t    wr_word;

   // ***************************************************************
   // read with same-edge write forwarding
   // ***************************************************************
   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < pspi_pkg::LANES; i++) begin
         wr_word[i] = {wr_par[i], wr_data[i*pspi_pkg::LANE_W +:
                                          pspi_pkg::LANE_W]};
      end
      if (rd_en) begin
         st_nxt.q = mem[rd_addr];
         for (int i = 0; i < pspi_pkg::LANES; i++) begin
            if (wr_en && wr_addr == rd_addr && !wr_lane_n[i]) begin
               st_nxt.q[i] = wr_word[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************************
   // lane writes, parity bit follows its byte
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (wr_en) begin
         for (int i = 0; i < pspi_pkg::LANES; i++) begin
            if (!wr_lane_n[i]) begin
               mem[wr_addr][i] <= wr_word[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < pspi_pkg::LANES; i++) begin
         q_data[i*pspi_pkg::LANE_W +: pspi_pkg::LANE_W] =
            st_r.q[i][pspi_pkg::LANE_W-1:0];
         q_par[i] = st_r.q[i][pspi_pkg::LANE_W];
      end
   end

endmodule
`default_nettype wire

// ### logic/pspi_top.sv
// Purpose: device-side pin interface of a pipelined burst sram
// Assumes: controller inputs share clk; output drive and jtag pins do not
// Notes:   jtag path is a single bypass bit showing edge timing only
`timescale 1ns/100ps
`default_nettype none
// Function
// - controller inputs taken only on qualified rising edges
// - select needs low, high, low selects
// - output drive low lets data pins drive
// - float on write data and deselect slots
// - qualify high freezes pipeline and read state
// - input data captured on rising edge
// - read data one stage after address
// - parity lane written with its byte
// - strap high interleaved, low linear
// - floating strap acts as high
// - test data out changes on falling
// - test data in sampled on rising
// - advance steps counter, low loads address
// - byte selects enable own lane writes
module pspi_top (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         resetn,
   // synchronous control
   input  wire logic                         clock_qualify_n,
   input  wire logic                         select_low_a,
   input  wire logic                         select_high,
   input  wire logic                         select_low_b,
   input  wire logic                         write_n,
   input  wire logic                         advance_or_load,
   input  wire logic [pspi_pkg::LANES-1:0]   byte_write_n,
   input  wire logic [pspi_pkg::ADDR_W-1:0]  address,
   // asynchronous output drive
   input  wire logic                         output_drive_n,
   // data pins
   input  wire logic [pspi_pkg::DATA_W-1:0]  data_in,
   output logic      [pspi_pkg::DATA_W-1:0]  data_out,
   output logic                              data_oe,
   // parity pins
   input  wire logic [pspi_pkg::LANES-1:0]   parity_in,
   output logic      [pspi_pkg::LANES-1:0]   parity_out,
   output logic                              parity_oe,
   // burst order strap
   input  wire logic                         burst_order_strap,
   input  wire logic                         burst_order_driven,
   // test port
   input  wire logic                         test_clk,
   input  wire logic                         test_din,
   output logic                              test_dout
);

   typedef struct packed {
      pspi_pkg::pspi_op_t                s1_op;
      logic [pspi_pkg::ADDR_W-1:0]       s1_addr;
      logic [pspi_pkg::BURST_W-1:0]      s1_base;
      logic [pspi_pkg::BURST_W-1:0]      s1_cnt;
      logic [pspi_pkg::LANES-1:0]        s1_bw_n;
      pspi_pkg::pspi_op_t                s2_op;
      logic [pspi_pkg::ADDR_W-1:0]       s2_addr;
      logic [pspi_pkg::LANES-1:0]        s2_bw_n;
      logic                              drive;
      logic [pspi_pkg::SYNC_N-1:0]       strap_s;
      logic [pspi_pkg::SYNC_N-1:0]       drv_s;
      logic [1:0]                        fill;
      logic                              mode;
      logic                              mode_done;
      logic [pspi_pkg::SYNC_N-1:0]       tck_s;
      logic                              tck_lvl;
      logic [pspi_pkg::SYNC_N-1:0]       tdi_s;
      logic                              tdi_lvl;
      logic                              tdi_cap;
      logic                              tdo;
   } pspi_state_t;

   localparam pspi_state_t ST_RST = '{
      s1_op:   pspi_pkg::OP_DESEL,
      s1_bw_n: pspi_pkg::BW_NONE,
      s2_op:   pspi_pkg::OP_DESEL,
      s2_bw_n: pspi_pkg::BW_NONE,
      mode:    pspi_pkg::MODE_FLOAT,
      default: '0
   };

   pspi_state_t st_r;
   pspi_state_t st_nxt;
   logic        qual;
   logic        sel;
   logic        tck_rise;
   logic        tck_fall;
   logic [1:0]  cnt_inc;

   // ***************************************************************
   // burst order of the two low address bits
   // ***************************************************************
   function automatic logic [1:0] burst_low(input logic [1:0] base,
                                            input logic [1:0] cnt,
                                            input logic       mode);
      logic [1:0] res;
      res = 2'h0;
      if (mode == pspi_pkg::MODE_INTERLEAVE) begin
         res = base ^ cnt;
      end else begin
         res = base + cnt;
      end
      return res;
   endfunction

   // ***************************************************************
   // access pipeline
   // ***************************************************************
   assign qual    = !clock_qualify_n;
   assign sel     = !select_low_a && select_high && !select_low_b;
   assign cnt_inc = st_r.s1_cnt + 2'h1;

   always_comb begin
      st_nxt = st_r;
      if (qual) begin
         st_nxt.s2_op   = st_r.s1_op;
         st_nxt.s2_addr = st_r.s1_addr;
         st_nxt.s2_bw_n = st_r.s1_bw_n;
         st_nxt.s1_bw_n = byte_write_n;
         if (!advance_or_load) begin
            if (sel) begin
               st_nxt.s1_op   = write_n ? pspi_pkg::OP_READ
                                        : pspi_pkg::OP_WRITE;
               st_nxt.s1_addr = address;
               st_nxt.s1_base = address[1:0];
               st_nxt.s1_cnt  = 2'h0;
            end else begin
               st_nxt.s1_op = pspi_pkg::OP_DESEL;
            end
         end else begin
            st_nxt.s1_cnt        = cnt_inc;
            st_nxt.s1_addr[1:0]  = burst_low(st_r.s1_base, cnt_inc,
                                             st_r.mode);
         end
         // data slot of a write or deselect stays floating
         st_nxt.drive = (st_r.s1_op == pspi_pkg::OP_READ);
      end

      // strap caught once after reset, pull-up when undriven
      st_nxt.strap_s = {st_r.strap_s[1:0], burst_order_strap};
      st_nxt.drv_s   = {st_r.drv_s[1:0], burst_order_driven};
      if (st_r.fill != pspi_pkg::STRAP_FILL) begin
         st_nxt.fill = st_r.fill + 2'h1;
      end else if (!st_r.mode_done &&
                   st_r.strap_s[1] == st_r.strap_s[2] &&
                   st_r.drv_s[1] == st_r.drv_s[2]) begin
         st_nxt.mode      = st_r.drv_s[2] ? st_r.strap_s[2]
                                          : pspi_pkg::MODE_FLOAT;
         st_nxt.mode_done = 1'b1;
      end

      // test clock and data filtered into this domain
      st_nxt.tck_s = {st_r.tck_s[1:0], test_clk};
      st_nxt.tdi_s = {st_r.tdi_s[1:0], test_din};
      if (st_r.tck_s[1] == st_r.tck_s[2]) begin
         st_nxt.tck_lvl = st_r.tck_s[2];
      end
      if (st_r.tdi_s[1] == st_r.tdi_s[2]) begin
         st_nxt.tdi_lvl = st_r.tdi_s[2];
      end
      tck_rise = st_nxt.tck_lvl && !st_r.tck_lvl;
      tck_fall = !st_nxt.tck_lvl && st_r.tck_lvl;
      if (tck_rise) begin
         st_nxt.tdi_cap = st_r.tdi_lvl;
      end
      if (tck_fall) begin
         st_nxt.tdo = st_r.tdi_cap;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************************
   // storage
   // ***************************************************************
   pspi_core u_core (
      .clk       (clk),
      .resetn    (resetn),
      .rd_en     (qual && st_r.s1_op == pspi_pkg::OP_READ),
      .rd_addr   (st_r.s1_addr),
      .q_data    (data_out),
      .q_par     (parity_out),
      .wr_en     (qual && st_r.s2_op == pspi_pkg::OP_WRITE),
      .wr_addr   (st_r.s2_addr),
      .wr_lane_n (st_r.s2_bw_n),
      .wr_data   (data_in),
      .wr_par    (parity_in)
   );

   // ***************************************************************
   // pin direction, shared by data and parity lanes
   // ***************************************************************
   assign data_oe   = st_r.drive && !output_drive_n;
   assign parity_oe = data_oe;
   assign test_dout = st_r.tdo;

   // ***************************************************************
   // checks
   // ***************************************************************
   a_freeze_hold:
   assert property (@(posedge clk) disable iff (!resetn)
      clock_qualify_n |=> $stable(st_r.s1_op) && $stable(st_r.s1_addr)
                          && $stable(st_r.drive) && $stable(st_r.s2_op))
   else $error("state moved while clock unqualified");

   a_select_read:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && !advance_or_load && sel && write_n
      |=> st_r.s1_op == pspi_pkg::OP_READ)
   else $error("selected read load not taken");

   a_select_miss:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && !advance_or_load && !sel
      |=> st_r.s1_op == pspi_pkg::OP_DESEL)
   else $error("load without full select not deselected");

   a_drive_gate:
   assert property (@(posedge clk) disable iff (!resetn)
      output_drive_n || !st_r.drive |-> !data_oe && !parity_oe)
   else $error("pins driven while drive input high");

   a_write_float:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && st_r.s1_op != pspi_pkg::OP_READ |=> !data_oe)
   else $error("pins driven in write or deselect slot");

   a_read_latency:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && !advance_or_load && sel && write_n ##1 qual
      |=> st_r.drive && $past(st_r.s1_addr) == $past(address, 2))
   else $error("read data slot not one stage after address");

   a_burst_order:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && advance_or_load && st_r.mode_done
      |=> st_r.s1_addr[1:0] == ($past(st_r.mode)
          ? ($past(st_r.s1_base) ^ $past(cnt_inc))
          : 2'($past(st_r.s1_base) + $past(cnt_inc))))
   else $error("burst address step in wrong order");

   a_strap_float:
   assert property (@(posedge clk) disable iff (!resetn)
      $rose(st_r.mode_done) |-> st_r.mode ==
         ($past(st_r.drv_s[2]) ? $past(st_r.strap_s[2])
                               : pspi_pkg::MODE_FLOAT))
   else $error("burst order strap captured wrongly");

   a_tdo_fall:
   assert property (@(posedge clk) disable iff (!resetn)
      $changed(st_r.tdo) |-> $fell(st_r.tck_lvl))
   else $error("test data out moved off falling edge");

   a_tdi_rise:
   assert property (@(posedge clk) disable iff (!resetn)
      $changed(st_r.tdi_cap) |-> $rose(st_r.tck_lvl))
   else $error("test data in sampled off rising edge");

   a_select_write:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && !advance_or_load && sel && !write_n
      |=> st_r.s1_op == pspi_pkg::OP_WRITE)
   else $error("selected write load not taken");

   a_load_addr:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && !advance_or_load && sel
      |=> st_r.s1_addr == $past(address) && st_r.s1_cnt == 2'h0)
   else $error("load did not take the new address");

   a_burst_step:
   assert property (@(posedge clk) disable iff (!resetn)
      qual && advance_or_load
      |=> $stable(st_r.s1_op)
          && st_r.s1_cnt == 2'($past(st_r.s1_cnt) + 2'h1))
   else $error("advance did not step the burst counter");

   a_lane_sample:
   assert property (@(posedge clk) disable iff (!resetn)
      qual |=> st_r.s1_bw_n == $past(byte_write_n))
   else $error("byte write selects not sampled");

   a_freeze_data:
   assert property (@(posedge clk) disable iff (!resetn)
      clock_qualify_n |=> $stable(data_out) && $stable(parity_out))
   else $error("read data moved while clock unqualified");

   a_mode_hold:
   assert property (@(posedge clk) disable iff (!resetn)
      st_r.mode_done |=> $stable(st_r.mode) && st_r.mode_done)
   else $error("burst order changed after capture");

endmodule
`default_nettype wire

// ### sim/pspi_bus_model.sv
// Purpose: controller side of the shared data and parity pins
// Assumes: bench sets drv_en and drv_val off the falling edge
// Notes:   released pins show the inverse of their last level
`timescale 1ns/100ps
`default_nettype none
module pspi_bus_model (
   // clock
   input  wire logic        clk,
   // device pins
   input  wire logic [63:0] data_out,
   input  wire logic        data_oe,
   input  wire logic [7:0]  parity_out,
   input  wire logic        parity_oe,
   output logic      [63:0] data_in,
   output logic      [7:0]  parity_in,
   // bench request
   input  wire logic        drv_en,
   input  wire logic [71:0] drv_val
);
   // ***************************************************************
   // pin levels
   // ***************************************************************
   logic [71:0] last_r = 72'h0;

   always_comb begin
      if (drv_en) begin
         {parity_in, data_in} = drv_val;
      end else begin
         data_in   = data_oe ? data_out : ~last_r[63:0];
         parity_in = parity_oe ? parity_out : ~last_r[71:64];
      end
   end

   always_ff @(posedge clk) begin
      last_r <= {parity_in, data_in};
   end
endmodule
`default_nettype wire

// ### sim/pspi_top_tb.sv
// Purpose: self-checking bench of the sram pin interface
// Assumes: inputs change at the falling edge
// Notes:   expected words come from a lane-merging reference array
`timescale 1ns/100ps
`default_nettype none
module pspi_top_tb;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        clock_qualify_n = 1'b0;
   logic [2:0]  sel = 3'h5;
   logic        write_n = 1'b1;
   logic        advance_or_load = 1'b0;
   logic [7:0]  byte_write_n = 8'hff;
   logic [18:0] address = 19'h0;
   logic        output_drive_n = 1'b0;
   logic        burst_order_strap = 1'b1;
   logic        burst_order_driven = 1'b1;
   logic        test_clk = 1'b0;
   logic        test_din = 1'b0;
   logic        drv_en = 1'b0;
   logic [71:0] drv_val = 72'h0;
   logic [63:0] data_in;
   logic [63:0] data_out;
   logic [7:0]  parity_in;
   logic [7:0]  parity_out;
   logic        data_oe;
   logic        parity_oe;
   logic        test_dout;
   int          n_fail = 0;
   int          n_tests = 0;
   logic [71:0] ref_mem [int];

   always #4 clk = ~clk;

   pspi_top pspi_top_inst (.clk(clk), .resetn(resetn),
      .clock_qualify_n(clock_qualify_n), .select_low_a(sel[2]),
      .select_high(sel[1]), .select_low_b(sel[0]), .write_n(write_n),
      .advance_or_load(advance_or_load), .byte_write_n(byte_write_n),
      .address(address), .output_drive_n(output_drive_n),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .parity_in(parity_in), .parity_out(parity_out),
      .parity_oe(parity_oe), .burst_order_strap(burst_order_strap),
      .burst_order_driven(burst_order_driven), .test_clk(test_clk),
      .test_din(test_din), .test_dout(test_dout));

   pspi_bus_model pspi_bus_model_inst (.clk(clk), .data_out(data_out),
      .data_oe(data_oe), .parity_out(parity_out), .parity_oe(parity_oe),
      .data_in(data_in), .parity_in(parity_in), .drv_en(drv_en),
      .drv_val(drv_val));

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic give_verdict();
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk_word(input logic [71:0] got, input logic [71:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   function automatic logic [71:0] merge(input logic [71:0] o,
      input logic [71:0] n, input logic [7:0] bw);
      for (int i = 0; i < 8; i++) begin
         if (!bw[i]) begin
            o[8*i+:8] = n[8*i+:8];
            o[64+i] = n[64+i];
         end
      end
      return o;
   endfunction

   function automatic logic [18:0] baddr(input logic [18:0] b, input int j,
      input logic m);
      return {b[18:2], m ? b[1:0] ^ 2'(j) : b[1:0] + 2'(j)};
   endfunction

   task automatic step(input logic [2:0] s, input logic wn, input logic adv,
      input logic [7:0] bw, input logic [18:0] a);
      @(negedge clk);
      sel = s;
      write_n = wn;
      advance_or_load = adv;
      byte_write_n = bw;
      address = a;
   endtask

   // write of n words; data for each edge lands two edges later
   task automatic wr_seq(input logic [2:0] s, input logic [18:0] a,
      input int n, input logic [7:0] bw, input logic m);
      logic [71:0] v [4];
      int          k;
      for (int j = 0; j < n; j++) begin
         v[j] = 72'({$urandom, $urandom, $urandom});
         k = baddr(a, j, m);
         if (s == 3'h2)
            ref_mem[k] = merge(ref_mem.exists(k) ? ref_mem[k] : 72'h0,
                               v[j], bw);
      end
      for (int i = 0; i <= n + 1; i++) begin
         step(i < n ? s : 3'h5, 1'b0, i > 0 && i < n, i < n ? bw : 8'hff, a);
         if (i == 2)
            chk_bit(data_oe, 1'b0);
         if (i >= 2) begin
            drv_en = 1'b1;
            drv_val = v[i-2];
         end
      end
      @(negedge clk);
      drv_en = 1'b0;
   endtask

   task automatic rd(input logic [18:0] a);
      step(3'h2, 1'b1, 1'b0, 8'hff, a);
      step(3'h5, 1'b1, 1'b0, 8'hff, a);
      @(negedge clk);
      chk_word({parity_out, data_out}, ref_mem[a]);
      chk_bit(data_oe, ~output_drive_n);
      chk_bit(parity_oe, ~output_drive_n);
   endtask

   task automatic do_reset(input logic st, input logic dr);
      @(negedge clk);
      resetn = 1'b0;
      burst_order_strap = st;
      burst_order_driven = dr;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      ref_mem.delete();
   endtask

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      logic [18:0] a;
      logic        b;
      logic        b_prev;
      void'($urandom(32'h2b02));
      for (int m = 0; m < 3; m++) begin
         do_reset(m == 2, m != 1);
         a = 19'({$urandom, 2'h1});
         wr_seq(3'h2, a, 4, 8'h00, m != 0);
         for (int j = 0; j < 4; j++)
            rd(baddr(a, j, m != 0));
      end
      for (int i = 0; i < 40; i++) begin
         a = 19'($urandom % 16);
         wr_seq(3'h2, a, 1, ref_mem.exists(a) ? 8'($urandom) : 8'h00,
                1'b1);
         rd(a);
      end
      output_drive_n = 1'b1;
      rd(a);
      output_drive_n = 1'b0;
      for (int s = 0; s < 8; s++) begin
         wr_seq(3'(s), a, 1, 8'h00, 1'b1);
         rd(a);
      end
      clock_qualify_n = 1'b1;
      repeat (3) begin
         step(3'h2, 1'b0, 1'b0, 8'h00, a);
         chk_word({parity_out, data_out}, ref_mem[a]);
         chk_bit(data_oe, 1'b1);
      end
      step(3'h5, 1'b1, 1'b0, 8'hff, a);
      clock_qualify_n = 1'b0;
      rd(a);
      b_prev = 1'b0;
      for (int i = 0; i < 4; i++) begin
         b = 1'($urandom);
         test_din = b;
         repeat (8) @(negedge clk);
         test_clk = 1'b1;
         repeat (8) @(negedge clk);
         test_din = ~b;
         repeat (8) @(negedge clk);
         chk_bit(test_dout, b_prev);
         test_clk = 1'b0;
         repeat (8) @(negedge clk);
         chk_bit(test_dout, b);
         b_prev = b;
      end
      give_verdict();
   end

   initial begin
      #160000;
      n_fail++;
      give_verdict();
   end
endmodule
`default_nettype wire
